// ### inc/tprl_pkg.sv
// Package for the pin rank loader: rank layout, word formats, host register map.
// Assumes both ends and the bench import it; no clock or reset is needed here.
package tprl_pkg;
	localparam int PIN_COUNT = 60;
	localparam int RANK_PINS = 15;
	localparam int RANK_COUNT = 4;
	localparam int RANK_WORD_W = 24;
	localparam int RANK_DATA_W = 16;
	// Select bit position inside a rank word: rank 1 carries define select, rank 2 mask select
	localparam int RANK_SEL_BIT = 15;
	localparam int LM_WORD_W = PIN_COUNT + 2;
	localparam int LM_DSEL_BIT = PIN_COUNT;
	localparam int LM_MSEL_BIT = PIN_COUNT + 1;
	localparam logic [RANK_DATA_W-1:0] HOLD_RESET = 16'h0000;
	localparam logic [PIN_COUNT-1:0] DEFINE_RESET = 60'h000000000000000;
	// Host register byte offsets
	localparam logic [3:0] REG_PAT_LO = 4'h0;
	localparam logic [3:0] REG_PAT_HI = 4'h4;
	localparam logic [3:0] REG_CMD = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	// Pattern low word: pins 1-30, then the two select bits
	localparam int PAT_DSEL_BIT = 30;
	localparam int PAT_MSEL_BIT = 31;
	// Command register fields
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_TGT_LSB = 1;
	localparam int CMD_ALL_BIT = 3;
	localparam int CMD_CLEAR_BIT = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {TGT_LOCAL, TGT_PRIMARY, TGT_ALTERNATE, TGT_NONE} tprl_target_type;
endpackage

// ### inc/tprl_rank_if.sv
// Rank word channel between the loading party and the tester pin logic.
// Assumes both ends share one clock; valid/ready handshake, one word per edge.
`timescale 1ns/1ns
`default_nettype none
interface tprl_rank_if;
	logic rank_valid;
	logic rank_ready;
	logic [1:0] rank_index;
	logic [tprl_pkg::RANK_WORD_W-1:0] rank_word;
	logic rank_last;
	tprl_pkg::tprl_target_type rank_target;
	modport host (output rank_valid, rank_index, rank_word, rank_last, rank_target,
		input rank_ready);
	modport device (input rank_valid, rank_index, rank_word, rank_last, rank_target,
		output rank_ready);
endinterface
`default_nettype wire

// ### hw/tprl_loader.sv
// Loading end: software orders pattern loads over AXI4-Lite, this end emits rank words.
// Assumes the device end on the rank interface and a single clock aclk.
`timescale 1ns/1ns
`default_nettype none
module tprl_loader (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	tprl_rank_if.host rank_bus
);
	import tprl_pkg::*;
	typedef enum logic {ST_IDLE, ST_SEND} tprl_host_state_type;
	tprl_host_state_type state;
	logic [31:0] pat_lo;
	logic [31:0] pat_hi;
	logic force_all;
	logic [RANK_DATA_W-1:0] shadow [RANK_COUNT];
	logic [RANK_DATA_W-1:0] want [RANK_COUNT];
	logic [RANK_COUNT-1:0] need;
	logic [RANK_COUNT-1:0] next_need;
	logic [1:0] cur;
	logic [15:0] sent_count;
	logic wr_fire;
	logic go;
	logic [PIN_COUNT-1:0] pins;

	// Writes are taken only when address and data are both offered
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = !s_axi_rvalid;
	assign go = wr_fire && s_axi_awaddr == REG_CMD && s_axi_wstrb[0] && s_axi_wdata[CMD_GO_BIT];
	assign pins = {pat_hi[29:0], pat_lo[29:0]};

	// Rank images of the requested pattern, select bits in ranks 1 and 2
	always_comb begin
		for (int r = 0; r < RANK_COUNT; r++) begin
			want[r] = {1'b0, pins[r*RANK_PINS +: RANK_PINS]};
		end
		want[0][RANK_SEL_BIT] = pat_lo[PAT_DSEL_BIT];
		want[1][RANK_SEL_BIT] = pat_lo[PAT_MSEL_BIT];
	end

	// Changed ranks, select changes included; forced loads take every rank
	always_comb begin
		for (int r = 0; r < RANK_COUNT; r++) begin
			next_need[r] = want[r] != shadow[r];
		end
		if (force_all || s_axi_wdata[CMD_ALL_BIT]) begin
			next_need = '1;
		end
		if (next_need == '0) begin
			next_need = 4'h1;
		end
	end

	// Register writes; clearing zeroes the staged pins and forces a full load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pat_lo <= 32'h00000000;
			pat_hi <= 32'h00000000;
			force_all <= 1'b1;
		end else if (wr_fire && s_axi_awaddr == REG_PAT_LO) begin
			for (int b = 0; b < 4; b++) begin
				if (s_axi_wstrb[b]) pat_lo[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
			end
		end else if (wr_fire && s_axi_awaddr == REG_PAT_HI) begin
			for (int b = 0; b < 4; b++) begin
				if (s_axi_wstrb[b]) pat_hi[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
			end
		end else if (wr_fire && s_axi_awaddr == REG_CMD && s_axi_wstrb[0]
				&& s_axi_wdata[CMD_CLEAR_BIT]) begin
			pat_lo <= 32'h00000000;
			pat_hi <= 32'h00000000;
			force_all <= 1'b1;
		end else if (go && state == ST_IDLE) begin
			force_all <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (s_axi_awaddr[1:0] != 2'h0 || s_axi_awaddr == REG_STATUS) ?
				RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				REG_PAT_LO: s_axi_rdata <= pat_lo;
				REG_PAT_HI: s_axi_rdata <= pat_hi;
				REG_CMD: s_axi_rdata <= 32'h00000000;
				REG_STATUS: s_axi_rdata <= {sent_count, 11'h000, need, state == ST_SEND};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Lowest pending rank goes first
	always_comb begin
		cur = 2'h3;
		for (int r = RANK_COUNT - 1; r >= 0; r--) begin
			if (need[r]) cur = r[1:0];
		end
	end

	assign rank_bus.rank_valid = state == ST_SEND;
	assign rank_bus.rank_index = cur;
	assign rank_bus.rank_word = {8'h00, want[cur]};
	assign rank_bus.rank_last = (need & ~(4'h1 << cur)) == '0;

	// Send state; a go command arriving while busy is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			need <= '0;
			rank_bus.rank_target <= TGT_NONE;
			sent_count <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (go) begin
						need <= next_need;
						rank_bus.rank_target <=
							tprl_target_type'(s_axi_wdata[CMD_TGT_LSB +: 2]);
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (rank_bus.rank_ready) begin
						need[cur] <= 1'b0;
						sent_count <= sent_count + 16'h0001;
						if (rank_bus.rank_last) state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Mirror of the device holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int r = 0; r < RANK_COUNT; r++) shadow[r] <= HOLD_RESET;
		end else if (state == ST_SEND && rank_bus.rank_ready) begin
			shadow[cur] <= want[cur];
		end
	end
endmodule
`default_nettype wire

// ### hw/tprl_pin_logic.sv
// Tester pin logic: four-rank holding register, local pattern memory and the
// primary/alternate input definition registers driving relays and driver switches.
// Assumes one clock; cycle_start marks the reference edge of each test cycle.
//
// Contract
// - Local memory loads through four-rank holding register
// - Loader rewrites rank 1/2 on select change
// - Loader writes all ranks at program landmarks
// - Unspecified pin values start as zero
// - Flow changes rewrite every specified rank
// - Primary and alternate define registers, one active
// - Pattern or external generator picks active register
// - Define bit one means pin is input
// - Relay driven by OR of both registers
// - Driver switch follows selected register bit
// - Level detectors always stay connected
// - Four ranks of fifteen pins, 24-bit words
// - Selection changes only at cycle reference edge
// - Primary selected before any pattern selection
`timescale 1ns/1ns
`default_nettype none
module tprl_pin_logic #(
	parameter int LM_ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	tprl_rank_if.device rank_bus,
	input wire logic load_addr_clear,
	input wire logic cycle_start,
	input wire logic [LM_ADDR_W-1:0] pattern_addr,
	input wire logic ext_select_en,
	input wire logic ext_select,
	output logic [LM_ADDR_W-1:0] load_addr,
	output logic [tprl_pkg::PIN_COUNT-1:0] pin_data,
	output logic mask_select,
	output logic alt_selected,
	output logic [tprl_pkg::PIN_COUNT-1:0] input_path_relay,
	output logic [tprl_pkg::PIN_COUNT-1:0] driver_switch,
	output logic [tprl_pkg::PIN_COUNT-1:0] level_detect_connect
);
	import tprl_pkg::*;
	localparam int LM_DEPTH = 1 << LM_ADDR_W;
	logic [RANK_DATA_W-1:0] hold [RANK_COUNT];
	logic [RANK_DATA_W-1:0] next_hold [RANK_COUNT];
	logic [LM_WORD_W-1:0] lm [LM_DEPTH];
	logic [LM_WORD_W-1:0] next_image;
	logic [PIN_COUNT-1:0] input_define_primary;
	logic [PIN_COUNT-1:0] input_define_alternate;
	logic take;
	logic commit;

	// Every word is accepted at once, so the loader never stalls here
	assign rank_bus.rank_ready = 1'b1;
	assign take = rank_bus.rank_valid;
	assign commit = take && rank_bus.rank_last;

	// Holding content as it stands after this edge, so the last word of a
	// load is already part of the copy taken on the same edge
	always_comb begin
		for (int r = 0; r < RANK_COUNT; r++) begin
			next_hold[r] = hold[r];
		end
		if (take) begin
			next_hold[rank_bus.rank_index] = rank_bus.rank_word[RANK_DATA_W-1:0];
		end
		for (int r = 0; r < RANK_COUNT; r++) begin
			next_image[r*RANK_PINS +: RANK_PINS] = next_hold[r][RANK_PINS-1:0];
		end
		next_image[LM_DSEL_BIT] = next_hold[0][RANK_SEL_BIT];
		next_image[LM_MSEL_BIT] = next_hold[1][RANK_SEL_BIT];
	end

	// Holding register: ranks not rewritten keep their content
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int r = 0; r < RANK_COUNT; r++) begin
				hold[r] <= HOLD_RESET;
			end
		end else if (take) begin
			hold[rank_bus.rank_index] <= rank_bus.rank_word[RANK_DATA_W-1:0];
		end
	end

	// Local memory: whole holding image copied into each new location.
	// No reset on the array; pattern words are defined only once loaded.
	always_ff @(posedge aclk) begin
		if (commit && rank_bus.rank_target == TGT_LOCAL) begin
			lm[load_addr] <= next_image;
		end
	end

	// Load address steps after every local memory word, wraps at the top
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_addr <= '0;
		end else if (load_addr_clear) begin
			load_addr <= '0;
		end else if (commit && rank_bus.rank_target == TGT_LOCAL) begin
			load_addr <= load_addr + LM_ADDR_W'(1);
		end
	end

	// Input definition registers take the pin image of the holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_define_primary <= DEFINE_RESET;
			input_define_alternate <= DEFINE_RESET;
		end else if (commit && rank_bus.rank_target == TGT_PRIMARY) begin
			input_define_primary <= next_image[PIN_COUNT-1:0];
		end else if (commit && rank_bus.rank_target == TGT_ALTERNATE) begin
			input_define_alternate <= next_image[PIN_COUNT-1:0];
		end
	end

	// Pattern step at the reference edge only; selection never moves mid-cycle.
	// The external generator, when enabled, overrides the pattern select bit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alt_selected <= 1'b0;
			mask_select <= 1'b0;
			pin_data <= '0;
		end else if (cycle_start) begin
			alt_selected <= ext_select_en ? ext_select : lm[pattern_addr][LM_DSEL_BIT];
			mask_select <= lm[pattern_addr][LM_MSEL_BIT];
			pin_data <= lm[pattern_addr][PIN_COUNT-1:0];
		end
	end

	// Pin electronics controls, registered; a 1 bit marks an input pin.
	// One clock behind the definition registers and the selection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			input_path_relay <= '0;
			driver_switch <= '0;
			level_detect_connect <= '1;
		end else begin
			input_path_relay <= input_define_primary | input_define_alternate;
			driver_switch <= alt_selected ? input_define_alternate : input_define_primary;
			level_detect_connect <= '1;
		end
	end
endmodule
`default_nettype wire

// ### dv/tprl_properties.sv
// Checker for the rank word channel between the two ends.
// Assumes the interface signals are wired in by name beside the interface.
`timescale 1ns/1ns
`default_nettype none
module tprl_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rank_valid,
	input wire logic rank_ready,
	input wire logic [1:0] rank_index,
	input wire logic [tprl_pkg::RANK_WORD_W-1:0] rank_word,
	input wire logic rank_last,
	input wire tprl_pkg::tprl_target_type rank_target
);
	import tprl_pkg::*;
	// One clock domain, so clock and disable are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ready_always: assert property (rank_ready) else $error("rank ready low");
	a_word_pad_zero: assert property (rank_valid |-> rank_word[23:16] == 8'h00)
		else $error("rank word padding not zero");
	a_sel_rank_only: assert property (rank_valid && rank_index[1] |-> !rank_word[15])
		else $error("select bit set in rank 3 or 4");
	a_valid_holds: assert property (rank_valid && !rank_last |=> rank_valid)
		else $error("load broken off before last word");
	a_index_rising: assert property (rank_valid && !rank_last |=> rank_index > $past(rank_index))
		else $error("rank order not ascending");
	a_last_idle: assert property (rank_valid && rank_last |=> !rank_valid)
		else $error("word offered right after last");
	a_target_stable: assert property (rank_valid && !rank_last |=> $stable(rank_target))
		else $error("target changed within a load");
	a_load_bounded: assert property (rank_valid |-> ##[0:3] rank_last)
		else $error("load longer than four ranks");
endmodule
`default_nettype wire

// ### dv/tester_pin_rank_loader_tb_top.sv
// Bench: AXI4-Lite orders into the loader, pattern execution on the pin logic.
// Assumes both ends joined by one rank interface on a single 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tester_pin_rank_loader_tb_top;
	import tprl_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic load_addr_clear, cycle_start, ext_select_en, ext_select, mask_select, alt_selected;
	logic [7:0] pattern_addr, load_addr;
	logic [59:0] pin_data, input_path_relay, driver_switch, level_detect_connect;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	localparam logic [59:0] PD = 60'h123456789ABCDEF;
	localparam logic [59:0] AD = 60'hFEDCBA987654321;
	localparam logic [59:0] L0 = 60'h5A5A5A5A5A5A5A5;
	localparam logic [29:0] H1 = 30'h2AAAAAAA;
	tprl_rank_if rif();
	tprl_loader tprl_loader_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rank_bus(rif));
	tprl_pin_logic tprl_pin_logic_inst (.aclk, .aresetn, .rank_bus(rif), .load_addr_clear,
		.cycle_start, .pattern_addr, .ext_select_en, .ext_select, .load_addr, .pin_data,
		.mask_select, .alt_selected, .input_path_relay, .driver_switch, .level_detect_connect);
	tprl_properties tprl_properties_inst (.aclk, .aresetn, .rank_valid(rif.rank_valid),
		.rank_ready(rif.rank_ready), .rank_index(rif.rank_index), .rank_word(rif.rank_word),
		.rank_last(rif.rank_last), .rank_target(rif.rank_target));
	// 40 ns period
	always #20 aclk = ~aclk;
	// Hang guard: the whole run needs well under this many cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 8000) begin
			fail_count++;
			test_done();
		end
	end
	task test_done;
		$display("mismatches %0d, compared %0d", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// Write: address and data offered together; bready stays high between writes,
	// so a back-to-back call never lowers and raises it in one time step
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		while (s_axi_awready !== 1'b1) @(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge aclk);
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		chk("bresp", 64'(er), 64'(s_axi_bresp));
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (s_axi_arready !== 1'b1) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		d = s_axi_rdata;
	endtask
	task ld(input logic [59:0] p, input logic ds, input logic ms);
		wr(REG_PAT_LO, {ms, ds, p[29:0]}, RESP_OKAY);
		wr(REG_PAT_HI, {2'b00, p[59:30]}, RESP_OKAY);
	endtask
	// Start a load and poll busy, since rank count varies with the pending set
	task go(input tprl_target_type t, input logic all);
		logic [31:0] s;
		wr(REG_CMD, {28'h0000000, all, t, 1'b1}, RESP_OKAY);
		s = 32'h00000001;
		while (s[0] !== 1'b0) rd(REG_STATUS, s);
	endtask
	// One test cycle; pin outputs lag the reference edge by one clock
	task run_cycle(input logic [7:0] a);
		pattern_addr <= a;
		cycle_start <= 1'b1;
		@(posedge aclk);
		cycle_start <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task t_load_defs;
		ld(PD, 1'b0, 1'b0);
		go(TGT_PRIMARY, 1'b1);
		ld(AD, 1'b0, 1'b0);
		go(TGT_ALTERNATE, 1'b1);
		wr(REG_STATUS, 32'h00000000, RESP_SLVERR);
		chk("relay after error write", 64'(PD | AD), 64'(input_path_relay));
	endtask
	// Second word rewrites only ranks 3 and 4; ranks 1 and 2 must carry over
	task t_local_carry;
		logic [31:0] s;
		ld(L0, 1'b1, 1'b1);
		go(TGT_LOCAL, 1'b1);
		chk("load_addr", 64'h1, 64'(load_addr));
		ld({H1, L0[29:0]}, 1'b1, 1'b1);
		go(TGT_LOCAL, 1'b0);
		chk("load_addr", 64'h2, 64'(load_addr));
		// Only ranks 3 and 4 went out: 8 + 4 + 2 words so far
		rd(REG_STATUS, s);
		chk("words sent", 64'h000E, 64'(s[31:16]));
		run_cycle(8'h01);
		chk("pins carried", 64'({H1, L0[29:0]}), 64'(pin_data));
	endtask
	task t_select;
		run_cycle(8'h00);
		chk("pins", 64'(L0), 64'(pin_data));
		chk("alt_selected", 64'h1, 64'(alt_selected));
		chk("mask_select", 64'h1, 64'(mask_select));
		chk("switch alt", 64'(AD), 64'(driver_switch));
		chk("relay", 64'(PD | AD), 64'(input_path_relay));
		ext_select_en <= 1'b1;
		ext_select <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("no mid-cycle change", 64'h1, 64'(alt_selected));
		run_cycle(8'h01);
		chk("alt_selected ext", 64'h0, 64'(alt_selected));
		chk("switch prim", 64'(PD), 64'(driver_switch));
		chk("relay", 64'(PD | AD), 64'(input_path_relay));
		chk("detect", 64'hFFFFFFFFFFFFFFF, 64'(level_detect_connect));
	endtask
	// Clear zeroes the staged pattern and forces a full load; a load with no
	// change still sends rank 1; a holding-only load leaves local memory alone
	task t_clear;
		logic [31:0] s;
		wr(REG_CMD, 32'h00000010, RESP_OKAY);
		rd(REG_PAT_LO, s);
		chk("pat_lo cleared", 64'h0, 64'(s));
		rd(REG_PAT_HI, s);
		chk("pat_hi cleared", 64'h0, 64'(s));
		go(TGT_NONE, 1'b0);
		chk("load_addr none", 64'h2, 64'(load_addr));
		load_addr_clear <= 1'b1;
		@(posedge aclk);
		load_addr_clear <= 1'b0;
		@(posedge aclk);
		chk("load_addr clear", 64'h0, 64'(load_addr));
		go(TGT_LOCAL, 1'b0);
		rd(REG_STATUS, s);
		chk("words sent", 64'h0013, 64'(s[31:16]));
		chk("load_addr next", 64'h1, 64'(load_addr));
		ext_select_en <= 1'b0;
		run_cycle(8'h00);
		chk("pins zero", 64'h0, 64'(pin_data));
		chk("mask_select off", 64'h0, 64'(mask_select));
		chk("alt_selected pat", 64'h0, 64'(alt_selected));
		chk("switch prim", 64'(PD), 64'(driver_switch));
	endtask
	initial begin
		aclk = 1'b0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, pattern_addr} <= 48'h0;
		{load_addr_clear, cycle_start, ext_select_en, ext_select} <= 4'h0;
		s_axi_wstrb <= 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("alt reset", 64'h0, 64'(alt_selected));
		chk("switch reset", 64'h0, 64'(driver_switch));
		chk("detect reset", 64'hFFFFFFFFFFFFFFF, 64'(level_detect_connect));
		t_load_defs();
		t_local_carry();
		t_select();
		t_clear();
		test_done();
	end
endmodule
`default_nettype wire
